// ---- inc/pcg_pkg.sv ----
// shared constants of the peripheral and usb clock gating block
package pcg_pkg;
    // register byte addresses; the usb control word index is not aligned,
    // so its byte address is four times the index
    localparam logic [15:0] PCG_IDX_USB_SYS_CTRL = 16'h1C32;
    localparam logic [15:0] PCG_OFF_USB_SYS_CTRL = 16'h70C8;
    localparam logic [15:0] PCG_OFF_STOP_HS = 16'h1C40;
    localparam logic [15:0] PCG_OFF_GATE_ONE = 16'h1C44;
    localparam logic [15:0] PCG_OFF_GATE_TWO = 16'h1C48;
    localparam logic [15:0] PCG_OFF_CLK_SRC = 16'h1C4C;
    localparam logic [15:0] PCG_OFF_STATUS = 16'h1C50;
    // usb system control fields
    localparam int PCG_BIT_PWDN = 15;
    localparam int PCG_BIT_SESSEND = 14;
    localparam int PCG_BIT_VBUSDET = 13;
    localparam int PCG_BIT_PLLREL = 12;
    localparam int PCG_BIT_DATPOL = 6;
    localparam int PCG_BIT_BIASDIS = 3;
    localparam int PCG_BIT_OSCDIS = 2;
    localparam logic [15:0] PCG_USCR_WMASK = 16'hF04F;
    localparam logic [15:0] PCG_USCR_RESET = 16'hA04C;
    // stop handshake fields: emif 0, usb 1, uart 2
    localparam int PCG_NUM_MOD = 3;
    localparam int PCG_MOD_USB = 1;
    // usb gate bit inside gate control two
    localparam int PCG_BIT_USB_GATE = 0;
    // clock source select: 0 generator, 1 external input, 2 rtc
    localparam logic [1:0] PCG_SRC_GEN = 2'h0;
    localparam logic [1:0] PCG_SRC_EXT = 2'h1;
    localparam logic [1:0] PCG_SRC_RTC = 2'h2;
    localparam int PCG_BIT_PLL_PWDN = 2;
    // usb oscillator and clocking figures
    localparam real PCG_USB_OSC_MHZ = 12.0;
    localparam int PCG_HS_MBPS = 480;
    localparam real PCG_CLK_MHZ = 10.0;
    localparam real PCG_OSC_STABLE_US = 100.0;
    localparam int PCG_OSC_STABLE_CYC =
        int'($ceil(PCG_OSC_STABLE_US * PCG_CLK_MHZ));
    // byte access encodings
    localparam logic [1:0] PCG_BYTE_WORD = 2'h0;
    localparam logic [1:0] PCG_BYTE_HIGH = 2'h1;
    localparam logic [1:0] PCG_BYTE_LOW = 2'h2;
    localparam logic [1:0] PCG_BYTE_RSVD = 2'h3;
endpackage

// ---- logic/pcg_ack_tracker.sv ----
// per-module clock stop acknowledge tracker
`timescale 1ns/100ps
module pcg_ack_tracker
    import pcg_pkg::*;
#(
    parameter int NUM = PCG_NUM_MOD
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // stop request from software and idle reports from modules
    input wire logic [NUM-1:0] stop_req,
    input wire logic [NUM-1:0] module_idle,
    // acknowledge back to software
    output logic [NUM-1:0] stop_ack
);
    initial begin
        if (NUM < 1) $error("pcg_ack_tracker needs at least one module");
    end

    typedef struct packed {
        logic [NUM-1:0] ack;
    } pcg_trk_t;

    pcg_trk_t st;
    pcg_trk_t next_st;

    // ack rises only when requested and idle, drops once request is gone
    always_comb begin
        next_st = st;
        next_st.ack = stop_req & (st.ack | module_idle);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stop_ack = st.ack;
endmodule

// ---- logic/pcg_top.sv ----
// peripheral and usb clock gating controller with apb registers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
//
// Function
// - module acks when stoppable; gate held open until ack is seen.
// - gate register writes act on gated clocks at once, no idle.
// - in bypass, system clock comes from external input or rtc.
// - bypassed generator pll keeps running unless powered down.
// - usb hs domain fed by usb pll from 12 MHz oscillator, 480 Mb/s.
// - full usb shutdown stops usb entirely, no suspend resume.
// - bit 15 powers down usb phy and pll; resets to one.
// - bit 14 enables session end comparator; resets to zero.
// - bit 13 enables vbus detect comparator.
// - oscillator disable tristates output pin, forces core clock low.
// - byte mode 0 word, 1 high byte, 2 low byte, 3 reserved.
// - polarity bit zero reverses dp and dm, one keeps normal.
module pcg_top
    import pcg_pkg::*;
#(
    parameter int GATE_W = 16,
    parameter int OSC_STABLE_CYC = PCG_OSC_STABLE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // stop handshake with emif, usb, uart
    input wire logic [PCG_NUM_MOD-1:0] module_idle,
    output logic [PCG_NUM_MOD-1:0] stop_request,
    // peripheral clock enables, one per gated clock
    output logic [GATE_W-1:0] gate_en_one,
    output logic [GATE_W-1:0] gate_en_two,
    // system clock source and pll
    output logic [1:0] system_clock_source,
    output logic pll_run,
    // usb analog and mode controls
    output logic usb_phy_pll_on,
    output logic session_end_comparator_en,
    output logic vbus_detect_comparator_en,
    output logic usb_pll_force_release,
    output logic usb_dp_dm_swap,
    output logic osc_bias_resistor_disable,
    output logic usb_osc_run,
    output logic usb_osc_core_clk_en,
    output logic usb_osc_output_pin_oe_n,
    output logic [1:0] cpu_byte_access_select,
    output logic usb_suspend_bit,
    output logic usb_fully_off,
    output logic usb_osc_stable
);
    initial begin
        if (GATE_W < 1 || GATE_W > 32) $error("GATE_W must be 1..32");
        if (OSC_STABLE_CYC < 1) $error("OSC_STABLE_CYC must be >= 1");
    end

    localparam int CW = $clog2(OSC_STABLE_CYC + 1);
    localparam logic [CW-1:0] STABLE_END = CW'(OSC_STABLE_CYC);

    // reset synchroniser
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    typedef struct packed {
        logic [15:0] uscr;
        logic [PCG_NUM_MOD-1:0] req;
        logic [GATE_W-1:0] gate1;
        logic [GATE_W-1:0] gate2;
        logic [1:0] src;
        logic pll_pwdn;
        logic suspend;
        logic [CW-1:0] settle;
        logic [31:0] rdata;
    } pcg_state_t;

    pcg_state_t st;
    pcg_state_t next_st;
    logic [PCG_NUM_MOD-1:0] ack;

    // acknowledge tracker: ack rises when module idle under request
    pcg_ack_tracker #(
        .NUM(PCG_NUM_MOD)
    ) u_ack (
        .clock(clock),
        .rst_n(rst_n),
        .stop_req(st.req),
        .module_idle(module_idle),
        .stop_ack(ack)
    );

    // address decode helper
    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        return a[15:2] == o[15:2];
    endfunction

    logic wr;
    logic rd;
    logic mapped;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign mapped = hit(paddr, PCG_OFF_USB_SYS_CTRL) ||
        hit(paddr, PCG_OFF_STOP_HS) || hit(paddr, PCG_OFF_GATE_ONE) ||
        hit(paddr, PCG_OFF_GATE_TWO) || hit(paddr, PCG_OFF_CLK_SRC) ||
        hit(paddr, PCG_OFF_STATUS);

    // register writes, read capture, oscillator settle counter
    always_comb begin
        next_st = st;
        if (wr && hit(paddr, PCG_OFF_USB_SYS_CTRL)) begin
            next_st.uscr = pwdata[15:0] & PCG_USCR_WMASK;
        end
        if (wr && hit(paddr, PCG_OFF_STOP_HS)) begin
            next_st.req = pwdata[PCG_NUM_MOD-1:0];
            next_st.suspend = pwdata[8];
        end
        if (wr && hit(paddr, PCG_OFF_GATE_ONE)) begin
            next_st.gate1 = pwdata[GATE_W-1:0];
        end
        if (wr && hit(paddr, PCG_OFF_GATE_TWO)) begin
            next_st.gate2 = pwdata[GATE_W-1:0];
        end
        if (wr && hit(paddr, PCG_OFF_CLK_SRC)) begin
            next_st.src = (pwdata[1:0] == PCG_SRC_RTC) ? PCG_SRC_RTC :
                (pwdata[1:0] == PCG_SRC_EXT) ? PCG_SRC_EXT : PCG_SRC_GEN;
            next_st.pll_pwdn = pwdata[PCG_BIT_PLL_PWDN];
        end
        // settle count restarts whenever the oscillator is off
        if (st.uscr[PCG_BIT_OSCDIS]) begin
            next_st.settle = '0;
        end else if (st.settle != STABLE_END) begin
            next_st.settle = st.settle + CW'(1);
        end
        // read data is registered in setup, returned in access
        if (rd) begin
            next_st.rdata = '0;
            if (hit(paddr, PCG_OFF_USB_SYS_CTRL)) begin
                next_st.rdata[15:0] = st.uscr;
            end else if (hit(paddr, PCG_OFF_STOP_HS)) begin
                next_st.rdata[PCG_NUM_MOD-1:0] = st.req;
                next_st.rdata[PCG_NUM_MOD+3:4] = ack;
                next_st.rdata[8] = st.suspend;
            end else if (hit(paddr, PCG_OFF_GATE_ONE)) begin
                next_st.rdata[GATE_W-1:0] = st.gate1;
            end else if (hit(paddr, PCG_OFF_GATE_TWO)) begin
                next_st.rdata[GATE_W-1:0] = st.gate2;
            end else if (hit(paddr, PCG_OFF_CLK_SRC)) begin
                next_st.rdata[1:0] = st.src;
                next_st.rdata[PCG_BIT_PLL_PWDN] = st.pll_pwdn;
            end else if (hit(paddr, PCG_OFF_STATUS)) begin
                next_st.rdata[0] = usb_osc_stable;
                next_st.rdata[1] = usb_fully_off;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st.uscr <= PCG_USCR_RESET;
            st.req <= '0;
            st.gate1 <= '0;
            st.gate2 <= '0;
            st.src <= PCG_SRC_GEN;
            st.pll_pwdn <= 1'b0;
            st.suspend <= 1'b0;
            st.settle <= '0;
            st.rdata <= '0;
        end else begin
            st <= next_st;
        end
    end

    // apb answer: zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st.rdata;

    // gate bit 1 stops the clock; stop-requested clocks stay open until ack
    // so a premature gate write cannot cut a busy module
    always_comb begin
        gate_en_one = ~st.gate1;
        gate_en_two = ~st.gate2;
        if (st.req[0] && !ack[0]) gate_en_one[0] = 1'b1;
        if (st.req[2] && !ack[2]) gate_en_one[1 % GATE_W] = 1'b1;
        if (st.req[PCG_MOD_USB] && !ack[PCG_MOD_USB]) begin
            gate_en_two[PCG_BIT_USB_GATE] = 1'b1;
        end
    end
    assign stop_request = st.req;

    // bypass selects external input or rtc; pll runs unless powered down
    assign system_clock_source = st.src;
    assign pll_run = !st.pll_pwdn;

    // usb analog controls; the usb pll multiplies the 12 MHz oscillator
    // up to the 480 Mb/s rate, so it needs the oscillator running
    assign usb_phy_pll_on = !st.uscr[PCG_BIT_PWDN] &&
        !st.uscr[PCG_BIT_OSCDIS];
    assign session_end_comparator_en = st.uscr[PCG_BIT_SESSEND];
    assign vbus_detect_comparator_en = st.uscr[PCG_BIT_VBUSDET];
    assign usb_pll_force_release = st.uscr[PCG_BIT_PLLREL];
    assign usb_dp_dm_swap = !st.uscr[PCG_BIT_DATPOL];
    assign osc_bias_resistor_disable = st.uscr[PCG_BIT_BIASDIS];
    assign usb_osc_run = !st.uscr[PCG_BIT_OSCDIS];
    assign usb_osc_core_clk_en = !st.uscr[PCG_BIT_OSCDIS];
    assign usb_osc_output_pin_oe_n = st.uscr[PCG_BIT_OSCDIS];
    // reserved byte code falls back to word access
    assign cpu_byte_access_select = (st.uscr[1:0] == PCG_BYTE_RSVD) ?
        PCG_BYTE_WORD : st.uscr[1:0];
    assign usb_suspend_bit = st.suspend;
    assign usb_osc_stable = (st.settle == STABLE_END);
    // fully off: gated, acked and oscillator down; no resume possible
    assign usb_fully_off = st.uscr[PCG_BIT_OSCDIS] &&
        st.gate2[PCG_BIT_USB_GATE] && ack[PCG_MOD_USB];
endmodule

// ---- dv/pcg_periph_model.sv ----
// behavioural model of the gated peripherals answering stop requests
`timescale 1ns/100ps
module pcg_periph_model
    import pcg_pkg::*;
(
    // clock, reset and answer speed
    input wire logic clock,
    input wire logic arst_n,
    input wire logic slow,
    // stop handshake
    input wire logic [PCG_NUM_MOD-1:0] stop_request,
    output logic [PCG_NUM_MOD-1:0] module_idle
);
    logic [3:0] cnt [PCG_NUM_MOD];

    // a module drains its work before it reports idle; the slow mode
    // lets the bench see the gate held open in the meantime
    always @(posedge clock or negedge arst_n) begin
        for (int i = 0; i < PCG_NUM_MOD; i++) begin
            if (!arst_n || !stop_request[i]) begin
                cnt[i] <= 4'h0;
                module_idle[i] <= 1'b0;
            end else if (cnt[i] == (slow ? 4'h8 : 4'h1)) begin
                module_idle[i] <= 1'b1;
            end else begin
                cnt[i] <= cnt[i] + 4'h1;
            end
        end
    end
endmodule

// ---- dv/pcg_top_checker.sv ----
// port assertions for the clock gating controller
`timescale 1ns/100ps
module pcg_checker
    import pcg_pkg::*;
#(
    parameter int GATE_W = 16,
    parameter int OSC_STABLE_CYC = 4
) (
    // clock, reset and apb
    input wire logic clock, arst_n, psel, penable, pwrite, pready,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    // handshake and gates
    input wire logic [PCG_NUM_MOD-1:0] module_idle, stop_request,
    input wire logic [GATE_W-1:0] gate_en_one, gate_en_two,
    // source, pll and usb controls
    input wire logic [1:0] system_clock_source, cpu_byte_access_select,
    input wire logic pll_run, usb_phy_pll_on, session_end_comparator_en,
    input wire logic vbus_detect_comparator_en, usb_dp_dm_swap,
    input wire logic usb_osc_core_clk_en, usb_osc_output_pin_oe_n,
    input wire logic usb_fully_off
);
    // completed writes to the usb control and clock source words
    wire wr = psel && penable && pready && pwrite;
    wire wr_u = wr && paddr == PCG_OFF_USB_SYS_CTRL;
    wire wr_s = wr && paddr == PCG_OFF_CLK_SRC;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_emif_gate_hold: assert property (stop_request[0] && !module_idle[0]
        && !$past(module_idle[0]) |-> gate_en_one[0]) else $error("emif gated early");
    a_usb_gate_hold: assert property (stop_request[1] && !module_idle[1]
        && !$past(module_idle[1]) |-> gate_en_two[0]) else $error("usb gated early");
    a_gate_write_now: assert property (wr && paddr == PCG_OFF_GATE_ONE
        && stop_request == 3'h0 |=> gate_en_one == ~$past(pwdata[GATE_W-1:0]))
        else $error("gate write late");
    a_source_select: assert property (wr_s |=> system_clock_source ==
        (($past(pwdata[1:0]) == 2'h3) ? PCG_SRC_GEN : $past(pwdata[1:0])))
        else $error("clock source wrong");
    a_pll_keeps_run: assert property (wr_s |=> pll_run == !$past(pwdata[2]))
        else $error("pll run wrong");
    a_usb_fully_off: assert property (usb_fully_off |->
        !gate_en_two[0] && !usb_osc_core_clk_en) else $error("usb not off");
    a_usb_power_down: assert property (wr_u |=> usb_phy_pll_on ==
        !($past(pwdata[15]) || $past(pwdata[2]))) else $error("phy power wrong");
    a_comparator_en: assert property (wr_u |=>
        session_end_comparator_en == $past(pwdata[14]) &&
        vbus_detect_comparator_en == $past(pwdata[13])) else $error("comparator");
    a_osc_pin_off: assert property (wr_u |=>
        usb_osc_output_pin_oe_n == $past(pwdata[2]) &&
        usb_osc_core_clk_en == !$past(pwdata[2])) else $error("osc pin wrong");
    a_byte_mode_sel: assert property (wr_u |=> cpu_byte_access_select ==
        (($past(pwdata[1:0]) == PCG_BYTE_RSVD) ? PCG_BYTE_WORD : $past(pwdata[1:0])))
        else $error("byte mode wrong");
    a_data_polarity: assert property (wr_u |=>
        usb_dp_dm_swap == !$past(pwdata[6])) else $error("polarity wrong");

    c_usb_off: cover property (usb_fully_off);
    c_rtc_source: cover property (wr_s && pwdata[1:0] == PCG_SRC_RTC);
    c_usb_idle: cover property (stop_request[1] && module_idle[1]);
endmodule

bind pcg_top pcg_checker #(.GATE_W(GATE_W), .OSC_STABLE_CYC(OSC_STABLE_CYC))
    chk_u (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
    .module_idle(module_idle), .stop_request(stop_request),
    .gate_en_one(gate_en_one), .gate_en_two(gate_en_two),
    .system_clock_source(system_clock_source), .cpu_byte_access_select(cpu_byte_access_select),
    .pll_run(pll_run), .usb_phy_pll_on(usb_phy_pll_on),
    .session_end_comparator_en(session_end_comparator_en),
    .vbus_detect_comparator_en(vbus_detect_comparator_en),
    .usb_dp_dm_swap(usb_dp_dm_swap), .usb_osc_core_clk_en(usb_osc_core_clk_en),
    .usb_osc_output_pin_oe_n(usb_osc_output_pin_oe_n),
    .usb_fully_off(usb_fully_off));

// ---- dv/peripheral_and_usb_clock_gating_tb.sv ----
// self-checking bench for the clock gating controller
`timescale 1ns/100ps
module peripheral_and_usb_clock_gating_tb
    import pcg_pkg::*;
;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slow = 1'b1, pready, pslverr, err;
    logic [15:0] paddr = 16'h0000, gate_en_one, gate_en_two;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] module_idle, stop_request;
    logic [1:0] src, bsel;
    logic pll_run, phy_on, ses, vbus, swap, osc_clk, oe_n, off, susp;
    int error_cnt = 0, n_compared = 0;

    pcg_top #(.GATE_W(16), .OSC_STABLE_CYC(4)) dut_u (.clock(clock),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .module_idle(module_idle),
        .stop_request(stop_request), .gate_en_one(gate_en_one),
        .gate_en_two(gate_en_two), .system_clock_source(src), .pll_run(pll_run),
        .usb_phy_pll_on(phy_on), .session_end_comparator_en(ses),
        .vbus_detect_comparator_en(vbus), .usb_pll_force_release(),
        .usb_dp_dm_swap(swap), .osc_bias_resistor_disable(), .usb_osc_run(),
        .usb_osc_core_clk_en(osc_clk), .usb_osc_output_pin_oe_n(oe_n),
        .cpu_byte_access_select(bsel), .usb_suspend_bit(susp),
        .usb_fully_off(off), .usb_osc_stable());
    pcg_periph_model model_u (.clock(clock), .arst_n(arst_n), .slow(slow),
        .stop_request(stop_request), .module_idle(module_idle));

    initial forever #50 clock = ~clock;

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; an idle edge after it keeps drivers apart
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin error_cnt++; conclude(); end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask

    // reads until every bit of the mask is set, with a bounded count
    task automatic poll(input logic [15:0] a, input logic [31:0] m);
        int n;
        n = 0;
        do begin apb(1'b0, a, 32'h0); n++; end while ((rd & m) != m && n < 30);
        check("poll", rd & m, m);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, PCG_OFF_USB_SYS_CTRL, 32'h0);
        check("uscr reset", rd, 32'h0000A04C);
        check("phy", phy_on, 32'h0);
        check("pin", oe_n, 32'h1);
        apb(1'b1, PCG_OFF_USB_SYS_CTRL, 32'hFFFFFFFF);
        apb(1'b0, PCG_OFF_USB_SYS_CTRL, 32'h0);
        check("uscr rsvd", rd, 32'h0000F04F);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, PCG_OFF_USB_SYS_CTRL, m | ((m % 2) ? 32'h6040 : 32'h0));
            check("byte", bsel, (m == 3) ? 32'h0 : m);
            check("swap", swap, 1 - m % 2);
            check("sess", ses, m % 2);
            check("vbus", vbus, m % 2);
            check("phy", phy_on, 32'h1);
            check("pin", oe_n, 32'h0);
        end
        apb(1'b1, 16'h1C60, 32'hFFFF);
        check("err", err, 32'h1);
        $display("test usb control done");
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, PCG_OFF_CLK_SRC, s | ((s % 2) ? 32'h4 : 32'h0));
            check("src", src, (s == 3) ? 32'h0 : s);
            check("pll", pll_run, 1 - s % 2);
        end
        $display("test clock source done");
        // no dma traffic runs here, so the request may go at once
        // no usb packet traffic runs, so the slow bench clock is safe
        apb(1'b1, PCG_OFF_STOP_HS, 32'h107);
        check("suspend", susp, 32'h1);
        apb(1'b1, PCG_OFF_GATE_ONE, 32'hFFFF);
        apb(1'b1, PCG_OFF_GATE_TWO, 32'h1);
        check("held one", gate_en_one[1:0], 32'h3);
        check("held two", gate_en_two[0], 32'h1);
        poll(PCG_OFF_STOP_HS, 32'h70);
        check("gate one", gate_en_one, 32'h0);
        check("gate two", gate_en_two, 32'hFFFE);
        apb(1'b1, PCG_OFF_USB_SYS_CTRL, 32'h6044);
        check("off", off, 32'h1);
        check("core clk", osc_clk, 32'h0);
        poll(PCG_OFF_STATUS, 32'h2);
        $display("test shutdown done");
        slow <= 1'b0;
        apb(1'b1, PCG_OFF_USB_SYS_CTRL, 32'h6040);
        poll(PCG_OFF_STATUS, 32'h1);
        apb(1'b1, PCG_OFF_GATE_ONE, 32'h0);
        apb(1'b1, PCG_OFF_GATE_TWO, 32'h0);
        check("gate two", gate_en_two, 32'hFFFF);
        apb(1'b1, PCG_OFF_STOP_HS, 32'h0);
        apb(1'b0, PCG_OFF_STOP_HS, 32'h0);
        check("ack clear", rd, 32'h0);
        check("suspend", susp, 32'h0);
        apb(1'b1, PCG_OFF_GATE_ONE, 32'hFFFC);
        check("gate one", gate_en_one, 32'h3);
        $display("test wake-up done");
        conclude();
    end
endmodule
